// ### tm3_pkg.sv
// Package for the timer-3 block: register map, field positions, reset values, prescale counts.
// Assumes an 8-bit special-function-register bus with one-cycle read and write strobes.
package tm3_pkg;
   localparam logic [7:0] TM3_ADDR_CTRL = 8'h91;
   localparam logic [7:0] TM3_ADDR_RLL = 8'h92;
   localparam logic [7:0] TM3_ADDR_RLH = 8'h93;
   localparam logic [7:0] TM3_ADDR_CNTL = 8'h94;
   localparam logic [7:0] TM3_ADDR_CNTH = 8'h95;
   localparam logic [7:0] TM3_RST_BYTE = 8'h00;
   // Control register field positions
   localparam int TM3_B_HOVF = 7;
   localparam int TM3_B_LOVF = 6;
   localparam int TM3_B_LIEN = 5;
   localparam int TM3_B_CAPEN = 4;
   localparam int TM3_B_SPLIT = 3;
   localparam int TM3_B_RUN = 2;
   localparam int TM3_B_XCLK = 0;
   localparam logic [7:0] TM3_CTRL_WMASK = 8'hfd;
   // Prescale counts
   localparam logic [3:0] TM3_SYS_DIV = 4'hc;
   localparam logic [3:0] TM3_EXT_DIV = 4'h8;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } tm3_bus_s;

   typedef struct packed {
      logic [7:0] ctrl;
      logic [7:0] rll;
      logic [7:0] rlh;
      logic [7:0] cntl;
      logic [7:0] cnth;
      logic [7:0] rdata;
      logic irq;
   } tm3_state_s;

   typedef struct packed {
      logic [3:0] sys_cnt;
      logic [2:0] ext_cnt;
      logic [2:0] ext_sync;
      logic [2:0] lfo_sync;
      logic sys_tick;
      logic ext_tick;
      logic lfo_fall;
   } tm3_pre_s;
endpackage

// ### tm3_prescale.sv
// Tick generator: system clock / 12, external clock / 8, slow-oscillator falling edge.
// Assumes ext_clk and lfo are asynchronous pins; both pass two flip-flops before use.
`timescale 1ns/10ps
`default_nettype none
module tm3_prescale
   import tm3_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Asynchronous pins
   input wire logic ext_clk,
   input wire logic lfo,
   // Tick outputs, one cycle each
   output logic sys_tick,
   output logic ext_tick,
   output logic lfo_fall
);
   tm3_pre_s s_r, s_nxt;

   always_comb begin
      s_nxt = s_r;
      s_nxt.ext_sync = {s_r.ext_sync[1:0], ext_clk};
      s_nxt.lfo_sync = {s_r.lfo_sync[1:0], lfo};
      s_nxt.sys_tick = 1'b0;
      s_nxt.ext_tick = 1'b0;
      // Edge detect uses stages 1 and 2, never the first flop
      s_nxt.lfo_fall = s_r.lfo_sync[2] & ~s_r.lfo_sync[1];
      if (s_r.sys_cnt == TM3_SYS_DIV - 4'h1) begin
         s_nxt.sys_cnt = 4'h0;
         s_nxt.sys_tick = 1'b1;
      end else begin
         s_nxt.sys_cnt = s_r.sys_cnt + 4'h1;
      end
      if (s_r.ext_sync[1] & ~s_r.ext_sync[2]) begin
         s_nxt.ext_cnt = s_r.ext_cnt + 3'h1;
         if (s_r.ext_cnt == 3'(TM3_EXT_DIV - 4'h1)) begin
            s_nxt.ext_tick = 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign sys_tick = s_r.sys_tick;
   assign ext_tick = s_r.ext_tick;
   assign lfo_fall = s_r.lfo_fall;

   // Eleven quiet cycles split in two, since one repetition may count to 8 at most
   a_sys_tick_period: assert property (@(posedge clk) disable iff (!rstn)
      sys_tick |=> !sys_tick [*8] ##1 !sys_tick [*3] ##1 sys_tick)
      else $error("system tick not every 12 cycles");
endmodule
`default_nettype wire

// ### tm3_timer.sv
// Timer 3: clock select, 16-bit or split 8-bit auto-reload, slow-oscillator capture.
// Assumes a special-function-register bus with one-cycle strobes; read data is registered.
`timescale 1ns/10ps
`default_nettype none
module tm3_timer
   import tm3_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Register bus
   input wire tm3_bus_s bus,
   output logic [7:0] rdata,
   // Per-byte clock selects from the clock control register
   input wire logic high_byte_clock_select,
   input wire logic low_byte_clock_select,
   // Asynchronous sources
   input wire logic ext_clk,
   input wire logic lfo,
   // Status out
   output logic [7:0] timer_control,
   output logic [15:0] count,
   output logic irq
);
   tm3_state_s s_r, s_nxt;
   logic sys_tick, ext_tick, lfo_fall;

   tm3_prescale u_pre (
      .clk(clk),
      .rstn(rstn),
      .ext_clk(ext_clk),
      .lfo(lfo),
      .sys_tick(sys_tick),
      .ext_tick(ext_tick),
      .lfo_fall(lfo_fall)
   );

   // Tick for one byte: per-byte select forces the system clock, else the shared choice
   function automatic logic byte_tick(input logic sel_sys, input logic xclk,
                                      input logic st, input logic et);
      byte_tick = sel_sys ? st : (xclk ? et : st);
   endfunction

   logic split, run, capen, tick_l, tick_h, inc_l, inc_h, wrap_l, wrap_h;
   logic [15:0] cnt16;

   always_comb begin
      split = s_r.ctrl[TM3_B_SPLIT];
      run = s_r.ctrl[TM3_B_RUN];
      capen = s_r.ctrl[TM3_B_CAPEN];
      // Per-byte select set means system clock divide-by-12 tick path (sys_tick)
      tick_l = byte_tick(low_byte_clock_select, s_r.ctrl[TM3_B_XCLK],
                         sys_tick, ext_tick);
      tick_h = split ? byte_tick(high_byte_clock_select, s_r.ctrl[TM3_B_XCLK],
                                 sys_tick, ext_tick) : tick_l;
      cnt16 = {s_r.cnth, s_r.cntl};
      if (split) begin
         inc_l = tick_l;
         inc_h = tick_h & run;
         wrap_l = inc_l & (s_r.cntl == 8'hff);
         wrap_h = inc_h & (s_r.cnth == 8'hff);
      end else begin
         inc_l = tick_l & run;
         inc_h = 1'b0;
         wrap_l = inc_l & (s_r.cntl == 8'hff);
         wrap_h = inc_l & (cnt16 == 16'hffff);
      end

      s_nxt = s_r;
      s_nxt.irq = 1'b0;
      // Counting; capture mode never reloads
      if (split) begin
         if (inc_l) begin
            s_nxt.cntl = (wrap_l && !capen) ? s_r.rll : s_r.cntl + 8'h01;
         end
         if (inc_h) begin
            s_nxt.cnth = (wrap_h && !capen) ? s_r.rlh : s_r.cnth + 8'h01;
         end
      end else if (inc_l) begin
         if (wrap_h && !capen) begin
            s_nxt.cntl = s_r.rll;
            s_nxt.cnth = s_r.rlh;
         end else begin
            {s_nxt.cnth, s_nxt.cntl} = cnt16 + 16'h0001;
         end
      end
      if (capen && lfo_fall) begin
         s_nxt.rll = s_r.cntl;
         s_nxt.rlh = s_r.cnth;
         s_nxt.irq = 1'b1;
      end

      // Software writes; hardware flag set wins over a clearing write
      if (bus.wr) begin
         unique case (bus.addr)
            TM3_ADDR_CTRL: s_nxt.ctrl = bus.wdata & TM3_CTRL_WMASK;
            TM3_ADDR_RLL: s_nxt.rll = bus.wdata;
            TM3_ADDR_RLH: s_nxt.rlh = bus.wdata;
            TM3_ADDR_CNTL: s_nxt.cntl = bus.wdata;
            TM3_ADDR_CNTH: s_nxt.cnth = bus.wdata;
            default: ;
         endcase
      end
      if (wrap_l) begin
         s_nxt.ctrl[TM3_B_LOVF] = 1'b1;
         if (s_r.ctrl[TM3_B_LIEN]) begin
            s_nxt.irq = 1'b1;
         end
      end
      if (wrap_h) begin
         s_nxt.ctrl[TM3_B_HOVF] = 1'b1;
         s_nxt.irq = 1'b1;
      end

      s_nxt.rdata = 8'h00;
      if (bus.rd) begin
         unique case (bus.addr)
            TM3_ADDR_CTRL: s_nxt.rdata = s_r.ctrl;
            TM3_ADDR_RLL: s_nxt.rdata = s_r.rll;
            TM3_ADDR_RLH: s_nxt.rdata = s_r.rlh;
            TM3_ADDR_CNTL: s_nxt.rdata = s_r.cntl;
            TM3_ADDR_CNTH: s_nxt.rdata = s_r.cnth;
            default: s_nxt.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign rdata = s_r.rdata;
   assign timer_control = s_r.ctrl;
   assign count = {s_r.cnth, s_r.cntl};
   assign irq = s_r.irq;

   sequence s_wrap16;
      !split && inc_l && cnt16 == 16'hffff && !capen && !bus.wr;
   endsequence
   sequence s_capture;
      capen && lfo_fall && !bus.wr;
   endsequence
   // Split wraps clear of writes and capture: only the reload moves the byte
   sequence s_split_wrap_low;
      split && inc_l && s_r.cntl == 8'hff && !capen && !bus.wr;
   endsequence
   sequence s_split_wrap_high;
      split && inc_h && s_r.cnth == 8'hff && !capen && !bus.wr;
   endsequence

   a_reload_16bit: assert property (@(posedge clk) disable iff (!rstn)
      s_wrap16 |=> count == {$past(s_r.rlh), $past(s_r.rll)})
      else $error("16-bit reload value not loaded");
   a_high_flag_set: assert property (@(posedge clk) disable iff (!rstn)
      wrap_h |=> timer_control[TM3_B_HOVF])
      else $error("high overflow flag not set");
   a_low_flag_set: assert property (@(posedge clk) disable iff (!rstn)
      wrap_l |=> timer_control[TM3_B_LOVF])
      else $error("low overflow flag not set");
   a_flag_sticky: assert property (@(posedge clk) disable iff (!rstn)
      timer_control[TM3_B_HOVF] && !$past(bus.wr) |-> $past(timer_control[TM3_B_HOVF])
         || $past(wrap_h))
      else $error("high flag set without wrap");
   a_capture_copy: assert property (@(posedge clk) disable iff (!rstn)
      s_capture |=> s_r.rll == $past(s_r.cntl) && s_r.rlh == $past(s_r.cnth) && irq)
      else $error("capture did not copy count");
   a_stop_holds: assert property (@(posedge clk) disable iff (!rstn)
      !split && !run && !bus.wr |=> $stable(count))
      else $error("count moved while stopped");
   a_split_low_runs: assert property (@(posedge clk) disable iff (!rstn)
      split && !run && tick_l && s_r.cntl != 8'hff && !bus.wr
         |=> s_r.cntl == $past(s_r.cntl) + 8'h01)
      else $error("split low byte did not count");
   a_incr_one: assert property (@(posedge clk) disable iff (!rstn)
      !split && inc_l && cnt16 != 16'hffff && !bus.wr |=> count == $past(cnt16) + 16'h0001)
      else $error("count step not one");
   a_write_count: assert property (@(posedge clk) disable iff (!rstn)
      bus.wr && bus.addr == TM3_ADDR_CNTH |=> s_r.cnth == $past(bus.wdata))
      else $error("high count write lost");
   a_split_reload_low: assert property (@(posedge clk) disable iff (!rstn)
      s_split_wrap_low |=> s_r.cntl == $past(s_r.rll))
      else $error("split low byte reload value not loaded");
   a_split_reload_high: assert property (@(posedge clk) disable iff (!rstn)
      s_split_wrap_high |=> s_r.cnth == $past(s_r.rlh))
      else $error("split high byte reload value not loaded");
   a_split_high_stops: assert property (@(posedge clk) disable iff (!rstn)
      split && !run && !bus.wr |=> s_r.cnth == $past(s_r.cnth))
      else $error("split high byte moved while stopped");
   a_ctrl_write: assert property (@(posedge clk) disable iff (!rstn)
      bus.wr && bus.addr == TM3_ADDR_CTRL && !wrap_l && !wrap_h
         |=> timer_control == ($past(bus.wdata) & TM3_CTRL_WMASK))
      else $error("control write not taken");
   a_read_count_low: assert property (@(posedge clk) disable iff (!rstn)
      bus.rd && bus.addr == TM3_ADDR_CNTL |=> rdata == $past(s_r.cntl))
      else $error("low count read wrong");
   a_low_irq: assert property (@(posedge clk) disable iff (!rstn)
      wrap_l && s_r.ctrl[TM3_B_LIEN] |=> irq)
      else $error("low wrap interrupt missing");
   a_irq_cause: assert property (@(posedge clk) disable iff (!rstn)
      !wrap_l && !wrap_h && !(capen && lfo_fall) |=> !irq)
      else $error("interrupt without a cause");
endmodule
`default_nettype wire

// ### timer3_clock_reload_capture_tb.sv
// Bench for the timer-3 block: registers, tick rates, reload, split mode, capture.
// Assumes the bench drives every pin; ext_clk and lfo change on clk edges.
`timescale 1ns/10ps
`default_nettype none
module timer3_clock_reload_capture_tb;
   import tm3_pkg::*;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   tm3_bus_s bus = '0;
   logic hs = 1'b0;
   logic ls = 1'b0;
   logic xc = 1'b0;
   logic xrun = 1'b0;
   logic xd = 1'b0;
   logic lfo = 1'b1;
   logic [7:0] rdata;
   logic [7:0] ctrl;
   logic [15:0] count;
   logic irq;
   logic [31:0] rng = 32'd71001;
   int failures = 0;
   int tests_run = 0;
   int irqs = 0;
   int n = 0;
   always #10 clk = ~clk;
   // External clock runs at a quarter of clk, so one tick every 32 cycles
   always @(posedge clk) begin
      if (irq === 1'b1) irqs <= irqs + 1;
      if (xrun) xd <= ~xd;
      if (xrun && xd) xc <= ~xc;
   end
   tm3_timer dut (.clk(clk), .rstn(rstn), .bus(bus), .rdata(rdata),
      .high_byte_clock_select(hs), .low_byte_clock_select(ls), .ext_clk(xc),
      .lfo(lfo), .timer_control(ctrl), .count(count), .irq(irq));
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   // One tick of the enabled bytes; a wrap loads the reload value
   function automatic logic [15:0] tick(input logic [15:0] c, input logic [15:0] r,
         input logic sp, input logic lo, input logic hi);
      logic [7:0] l;
      logic [7:0] h;
      if (!sp) return (c == 16'hffff) ? r : c + 16'h0001;
      l = !lo ? c[7:0] : (c[7:0] == 8'hff) ? r[7:0] : c[7:0] + 8'h01;
      h = !hi ? c[15:8] : (c[15:8] == 8'hff) ? r[15:8] : c[15:8] + 8'h01;
      return {h, l};
   endfunction
   task automatic print_verdict();
      $display("Checks %0d, failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("ERROR at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      bus <= '{1'b1, 1'b0, a, d};
      @(posedge clk);
      bus.wr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      bus <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge clk);
      bus.rd <= 1'b0;
      #1 chk({8'h00, rdata}, {8'h00, e});
   endtask
   // Waits for the next count change, leaves the cycles taken in n
   task automatic step(input logic [15:0] e, input int lim);
      logic [15:0] c0;
      c0 = count;
      for (n = 1; n <= lim; n++) begin
         @(posedge clk);
         #1;
         if (count !== c0) break;
      end
      chk(count, e);
      if (n > lim) print_verdict();
   endtask
   initial begin
      logic [15:0] r;
      int m;
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      for (logic [7:0] a = 8'h90; a < 8'h97; a++) rd(a, TM3_RST_BYTE);
      for (int k = 0; k < 8; k++) begin
         rng = xs(rng);
         wr(TM3_ADDR_RLL + k[1:0], rng[7:0]);
         rd(TM3_ADDR_RLL + k[1:0], rng[7:0]);
      end
      wr(TM3_ADDR_CTRL, 8'h02);
      rd(TM3_ADDR_CTRL, 8'h00);
      rng = xs(rng);
      r = {rng[15:8], 1'b0, rng[6:0]};
      wr(TM3_ADDR_RLL, r[7:0]);
      wr(TM3_ADDR_RLH, r[15:8]);
      wr(TM3_ADDR_CNTL, 8'hfe);
      wr(TM3_ADDR_CNTH, 8'hff);
      wr(TM3_ADDR_CTRL, 8'h04);
      step(16'hffff, 30);
      step(r, 30);
      chk(n[15:0], 16'd12);
      step(tick(r, r, 1'b0, 1'b1, 1'b1), 30);
      repeat (40) @(posedge clk);
      #1 chk({14'h0, ctrl[7:6]}, 16'h0003);
      chk({15'h0, irqs != 0}, 16'h0001);
      wr(TM3_ADDR_CTRL, 8'h05);
      rd(TM3_ADDR_CTRL, 8'h05);
      xrun <= 1'b1;
      r = count;
      step(r + 16'h0001, 200);
      step(r + 16'h0002, 200);
      chk(n[15:0], 16'd32);
      xrun <= 1'b0;
      wr(TM3_ADDR_CTRL, 8'h28);
      wr(TM3_ADDR_RLL, 8'ha0);
      wr(TM3_ADDR_RLH, 8'h5a);
      wr(TM3_ADDR_CNTH, 8'hff);
      wr(TM3_ADDR_CNTL, 8'hff);
      step(tick(16'hffff, 16'h5aa0, 1'b1, 1'b1, 1'b0), 30);
      chk({14'h0, ctrl[7:6]}, 16'h0001);
      wr(TM3_ADDR_CTRL, 8'h0c);
      r = count;
      step(tick(r, 16'h5aa0, 1'b1, 1'b1, 1'b1), 30);
      chk({14'h0, ctrl[7:6]}, 16'h0002);
      hs <= 1'b1;
      wr(TM3_ADDR_CTRL, 8'h0d);
      r = count;
      step(tick(r, 16'h5aa0, 1'b1, 1'b0, 1'b1), 30);
      hs <= 1'b0;
      ls <= 1'b1;
      r = count;
      step(tick(r, 16'h5aa0, 1'b1, 1'b1, 1'b0), 30);
      ls <= 1'b0;
      wr(TM3_ADDR_CTRL, 8'h10);
      rng = xs(rng);
      wr(TM3_ADDR_CNTL, rng[7:0]);
      wr(TM3_ADDR_CNTH, rng[15:8]);
      m = irqs;
      @(posedge clk);
      lfo <= 1'b0;
      repeat (8) @(posedge clk);
      rd(TM3_ADDR_RLL, rng[7:0]);
      rd(TM3_ADDR_RLH, rng[15:8]);
      chk({15'h0, irqs > m}, 16'h0001);
      print_verdict();
   end
endmodule
`default_nettype wire
